//--- rtl/fpir_pkg.sv
package fpir_pkg;
  localparam logic [7:0]  FPIR_PTR_OFS        = 8'h05;
  localparam logic [7:0]  FPIR_DATA_OFS       = 8'h06;
  localparam logic [6:0]  FPIR_IDX_FREQ       = 7'h00;
  localparam logic [6:0]  FPIR_IDX_VALUE      = 7'h01;
  localparam logic [6:0]  FPIR_IDX_MODE       = 7'h04;
  localparam logic [6:0]  FPIR_IDX_BANK       = 7'h4e;
  localparam logic [6:0]  FPIR_IDX_VALUE_PROG = 7'h09;
  localparam logic [7:0]  FPIR_BANK0          = 8'h00;
  localparam logic [7:0]  FPIR_BANK1          = 8'h01;
  localparam logic [7:0]  FPIR_FREQ_RST       = 8'h04;
  localparam logic [7:0]  FPIR_VALUE_RST      = 8'h7f;
  localparam logic        FPIR_MODE_RST       = 1'b1;
  localparam logic [7:0]  FPIR_DUTY_MAX       = 8'hfe;
  localparam int          FPIR_CLK_HZ         = 100000000;
  localparam int          FPIR_SRC0_HZ        = 93900;
  localparam int          FPIR_SRC1_HZ        = 1008;
  localparam int          FPIR_PWM_STEPS      = 255;
  // Tick rates are source rate times 255 steps, period rounded down
  localparam int          FPIR_TICK0_CYC      = FPIR_CLK_HZ / (FPIR_SRC0_HZ * FPIR_PWM_STEPS);
  localparam int          FPIR_TICK1_CYC      = FPIR_CLK_HZ / (FPIR_SRC1_HZ * FPIR_PWM_STEPS);
  localparam int          FPIR_DIV_W          = 11;
  localparam int          FPIR_BASE_W         = 16;
  localparam int          FPIR_CYC_W          = 9;
endpackage

//--- rtl/fpir_pwm_core.sv
`timescale 1ns/10ps
module fpir_pwm_core
  import fpir_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] freq_cfg_in,
  input  wire logic [7:0] duty_in,
  output logic            pwm_out
);
  logic [FPIR_CYC_W-1:0] cyc_reg, cyc_next;
  logic [FPIR_DIV_W-1:0] div_reg, div_next;
  logic [7:0]            step_reg, step_next;
  logic                  pwm_reg, pwm_next;
  logic                  src_tick, div_tick;
  logic [FPIR_CYC_W-1:0] cyc_lim;
  logic [FPIR_DIV_W-1:0] div_lim;

  function automatic logic [FPIR_DIV_W-1:0] fpir_map_div(input logic [3:0] code);
    logic [FPIR_DIV_W-1:0] m;
    m = '0;
    case (code)
      4'h8:    m = 11'd12;
      4'h9:    m = 11'd16;
      4'ha:    m = 11'd32;
      4'hb:    m = 11'd64;
      4'hc:    m = 11'd128;
      4'hd:    m = 11'd256;
      4'he:    m = 11'd512;
      4'hf:    m = 11'd1024;
      default: m = FPIR_DIV_W'(code) + 11'd1;
    endcase
    return m;
  endfunction

  always_comb begin
    cyc_lim = freq_cfg_in[7] ? FPIR_CYC_W'(FPIR_TICK1_CYC - 1)
                             : FPIR_CYC_W'(FPIR_TICK0_CYC - 1);
    div_lim = freq_cfg_in[7] ? fpir_map_div(freq_cfg_in[3:0]) - 11'd1
                             : FPIR_DIV_W'(freq_cfg_in[6:0]);
    src_tick  = (cyc_reg >= cyc_lim);
    cyc_next  = src_tick ? '0 : cyc_reg + 1'b1;
    div_tick  = src_tick && (div_reg >= div_lim);
    div_next  = div_reg;
    if (src_tick) begin
      div_next = div_tick ? '0 : div_reg + 1'b1;
    end
    step_next = step_reg;
    if (div_tick) begin
      step_next = (step_reg >= FPIR_DUTY_MAX) ? 8'h00 : step_reg + 8'h01;
    end
    pwm_next = (step_reg < duty_in);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_reg  <= '0;
      div_reg  <= '0;
      step_reg <= 8'h00;
      pwm_reg  <= 1'b0;
    end else begin
      cyc_reg  <= cyc_next;
      div_reg  <= div_next;
      step_reg <= step_next;
      pwm_reg  <= pwm_next;
    end
  end

  assign pwm_out = pwm_reg;
endmodule

//--- rtl/fpir_top.sv
`timescale 1ns/10ps
module fpir_top
  import fpir_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] base_address_high_byte_in,
  input  wire logic [7:0] base_address_low_byte_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic       io_wr_in,
  input  wire logic       io_rd_in,
  input  wire logic [7:0] io_wdata_in,
  output logic [7:0]      io_rdata_out,
  output logic            io_hit_out,
  output logic            system_fan_output_out,
  output logic [5:0]      dc_level_out,
  output logic            fan_output_mode_select_out
);
  logic       rst_s1_reg, rst_n;
  logic [6:0] ptr_reg, ptr_next;
  logic [7:0] bank_reg, bank_next;
  logic [7:0] freq_reg, freq_next;
  logic [7:0] value_reg, value_next;
  logic       mode_reg, mode_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [5:0] dc_reg, dc_next;
  logic [FPIR_BASE_W-1:0] base;
  logic       hit_ptr, hit_data, pwm_raw;
  logic [7:0] sel_rd;
  logic [7:0] freq_eff;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  always_comb begin
    base     = {base_address_high_byte_in, base_address_low_byte_in};
    hit_ptr  = (io_addr_in == base + 16'(FPIR_PTR_OFS));
    hit_data = (io_addr_in == base + 16'(FPIR_DATA_OFS));
    sel_rd   = 8'h00;
    if (ptr_reg == FPIR_IDX_BANK) begin
      sel_rd = bank_reg;
    end else if (bank_reg == FPIR_BANK0) begin
      case (ptr_reg)
        FPIR_IDX_FREQ:  sel_rd = freq_reg;
        FPIR_IDX_VALUE: sel_rd = value_reg;
        FPIR_IDX_MODE:  sel_rd = {7'h00, mode_reg};
        default:        sel_rd = 8'h00;
      endcase
    end else if (bank_reg == FPIR_BANK1 && ptr_reg == FPIR_IDX_VALUE_PROG) begin
      sel_rd = value_reg;
    end
  end

  always_comb begin
    ptr_next   = ptr_reg;
    bank_next  = bank_reg;
    freq_next  = freq_reg;
    value_next = value_reg;
    mode_next  = mode_reg;
    rdata_next = rdata_reg;
    if (io_rd_in && hit_ptr) begin
      rdata_next = {1'b0, ptr_reg};
    end else if (io_rd_in && hit_data) begin
      rdata_next = sel_rd;
    end
    if (io_wr_in && hit_ptr) begin
      ptr_next = io_wdata_in[6:0];
    end else if (io_wr_in && hit_data) begin
      if (ptr_reg == FPIR_IDX_BANK) begin
        bank_next = io_wdata_in;
      end else if (bank_reg == FPIR_BANK0) begin
        case (ptr_reg)
          FPIR_IDX_FREQ: freq_next = io_wdata_in;
          FPIR_IDX_MODE: mode_next = io_wdata_in[0];
          default:       ;
        endcase
        // Index 01 in bank 0 ignores writes
      end else if (bank_reg == FPIR_BANK1 && ptr_reg == FPIR_IDX_VALUE_PROG) begin
        value_next = io_wdata_in;
      end
    end
    dc_next = value_reg[7:2];
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg   <= 7'h00;
      bank_reg  <= FPIR_BANK0;
      freq_reg  <= FPIR_FREQ_RST;
      value_reg <= FPIR_VALUE_RST;
      mode_reg  <= FPIR_MODE_RST;
      rdata_reg <= 8'h00;
      dc_reg    <= 6'h00;
    end else begin
      ptr_reg   <= ptr_next;
      bank_reg  <= bank_next;
      freq_reg  <= freq_next;
      value_reg <= value_next;
      mode_reg  <= mode_next;
      rdata_reg <= rdata_next;
      dc_reg    <= dc_next;
    end
  end

  // Frequency held at reset value while in DC mode
  assign freq_eff = mode_reg ? FPIR_FREQ_RST : freq_reg;

  fpir_pwm_core u_pwm (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .freq_cfg_in (freq_eff),
    .duty_in     (value_reg),
    .pwm_out     (pwm_raw)
  );

  assign system_fan_output_out      = mode_reg ? 1'b0 : pwm_raw;
  assign dc_level_out               = mode_reg ? dc_reg : 6'h00;
  assign fan_output_mode_select_out = mode_reg;
  assign io_rdata_out               = rdata_reg;
  assign io_hit_out                 = hit_ptr | hit_data;
endmodule

//--- verification/fpir_checker.sv
`timescale 1ns/10ps
module fpir_checker (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic [7:0]  base_address_high_byte_in,
  input wire logic [7:0]  base_address_low_byte_in,
  input wire logic [15:0] io_addr_in,
  input wire logic        io_wr_in,
  input wire logic        io_rd_in,
  input wire logic [7:0]  io_rdata_out,
  input wire logic        io_hit_out,
  input wire logic        system_fan_output_out,
  input wire logic [5:0]  dc_level_out,
  input wire logic        fan_output_mode_select_out
);
  wire logic [15:0] b = {base_address_high_byte_in, base_address_low_byte_in};
  wire logic        md = fan_output_mode_select_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_hit_ptr: assert property (io_addr_in == b + 16'h0005 |-> io_hit_out)
    else $error("pointer port not decoded");
  a_hit_miss: assert property (io_addr_in != b + 16'h0005 && io_addr_in != b + 16'h0006
    |-> !io_hit_out) else $error("stray port decoded");
  a_rdata_hold: assert property (!(io_rd_in && io_hit_out) |=> $stable(io_rdata_out))
    else $error("read data moved without read");
  a_ptr_bit7: assert property (io_rd_in && io_addr_in == b + 16'h0005
    |=> !io_rdata_out[7]) else $error("pointer bit 7 set");
  a_dc_no_pwm: assert property (md [*2] |-> !system_fan_output_out)
    else $error("pulse in voltage mode");
  a_pwm_no_dc: assert property (!md [*2] |-> dc_level_out == 6'h00)
    else $error("level in pulse mode");
  a_mode_hold: assert property (!(io_wr_in && io_hit_out) |=> $stable(md))
    else $error("mode moved without write");
  a_reset_vals: assert property ($rose(reset_n_in) |-> md && io_rdata_out == 8'h00)
    else $error("bad reset values");
endmodule
bind fpir_top fpir_checker fpir_checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .base_address_high_byte_in(base_address_high_byte_in),
  .base_address_low_byte_in(base_address_low_byte_in), .io_addr_in(io_addr_in),
  .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_rdata_out(io_rdata_out),
  .io_hit_out(io_hit_out), .system_fan_output_out(system_fan_output_out),
  .dc_level_out(dc_level_out), .fan_output_mode_select_out(fan_output_mode_select_out));

//--- verification/fpir_host.sv
`timescale 1ns/10ps
// Idle lines show the inverted last value so stale data is never mistaken
module fpir_host (
  input  wire logic        clk_in,
  input  wire logic [7:0]  rdata_in,
  output logic      [15:0] addr_out = 16'h0000,
  output logic             wr_out = 1'b0,
  output logic             rd_out = 1'b0,
  output logic      [7:0]  wdata_out = 8'h00
);
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    #1 d = rdata_in;
  endtask
endmodule

//--- verification/fpir_top_tb.sv
`timescale 1ns/10ps
module fpir_top_tb;
  import fpir_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [15:0] base = 16'h0000;
  logic [15:0] addr;
  logic        wr, rd, pwm, mode;
  logic [7:0]  wdata, rdata, got;
  logic [5:0]  dcl;
  logic [31:0] seed = 32'h09dd_0a5f;
  logic [6:0]  idx[5] = '{7'h00, 7'h01, 7'h04, 7'h4e, 7'h33};
  int          n_mismatch = 0, compares = 0, cyc = 0, hi, c;
  int          bank_m = 0, freq_m = 4, val_m = 'h7f, mode_m = 1;
  always #5 clk_in = ~clk_in;
  fpir_host fpir_host_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata));
  fpir_top fpir_top_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .base_address_high_byte_in(base[15:8]), .base_address_low_byte_in(base[7:0]),
    .io_addr_in(addr), .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .io_rdata_out(rdata),
    .io_hit_out(), .system_fan_output_out(pwm), .dc_level_out(dcl),
    .fan_output_mode_select_out(mode));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic int exp_rd(int i);
    if (i == 'h4e) return bank_m;
    if (bank_m == 0) return i == 0 ? freq_m : i == 1 ? val_m : i == 4 ? mode_m : 0;
    return i == 9 ? val_m : 0;
  endfunction
  task automatic chk(input logic [15:0] g, input int e);
    compares++;
    if (g !== 16'(e)) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic reg_wr(input logic [6:0] i, input logic [7:0] d);
    fpir_host_i.wr(base + 16'h0005, {1'b0, i});
    fpir_host_i.wr(base + 16'h0006, d);
    if (i == 7'h4e) bank_m = d;
    else if (bank_m == 0 && i == 0) freq_m = d;
    else if (bank_m == 0 && i == 4) mode_m = d[0];
    else if (bank_m == 1 && i == 9) val_m = d;
  endtask
  task automatic reg_rd(input logic [6:0] i);
    fpir_host_i.wr(base + 16'h0005, {1'b0, i});
    fpir_host_i.rd(base + 16'h0006, got);
    chk({8'h00, got}, exp_rd(i));
  endtask
  task automatic duty(input logic [7:0] v, input int d);
    reg_wr(7'h4e, 8'h01);
    reg_wr(7'h09, v);
    reg_wr(7'h4e, 8'h00);
    reg_rd(7'h01);
    reg_wr(7'h00, 8'(d));
    repeat (2 * 255 * FPIR_TICK0_CYC * (d + 1)) @(posedge clk_in);
    hi = 0;
    repeat (255 * FPIR_TICK0_CYC * (d + 1)) @(posedge clk_in) hi += pwm;
    chk(16'(hi), v * FPIR_TICK0_CYC * (d + 1));
  endtask
  // Slow source switched in during step zero, so that step spans m slow ticks
  task automatic slow_pulse(input logic [3:0] code, input int m);
    reg_wr(7'h4e, 8'h01);
    reg_wr(7'h09, 8'h01);
    reg_wr(7'h4e, 8'h00);
    reg_wr(7'h00, 8'h00);
    @(negedge pwm);
    @(posedge pwm);
    fpir_host_i.wr(base + 16'h0006, {4'h8, code});
    freq_m = {4'h8, code};
    hi = 1;
    while (pwm) begin
      hi++;
      @(posedge clk_in);
    end
    chk(16'(hi), FPIR_TICK1_CYC * m);
  endtask
  task automatic final_report();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 45000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    base <= {rnd(), rnd() & 8'hf0};
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({15'h0000, mode}, mode_m);
    foreach (idx[k]) reg_rd(idx[k]);
    hi = rnd();
    fpir_host_i.wr(base + 16'h0005, 8'(hi) | 8'h80);
    fpir_host_i.rd(base + 16'h0005, got);
    chk({8'h00, got}, hi & 'h7f);
    reg_wr(7'h01, 8'h00);
    reg_rd(7'h01);
    reg_wr(7'h00, rnd());
    reg_rd(7'h00);
    chk({10'h000, dcl}, val_m >> 2);
    reg_wr(7'h04, 8'h00);
    @(posedge clk_in);
    chk({15'h0000, mode}, mode_m);
    duty(8'h00, 0);
    duty(8'hff, 1);
    duty(rnd(), 0);
    slow_pulse(4'h8, 12);
    c = rnd() & 8'h07;
    slow_pulse(4'(c), c + 1);
    reg_wr(7'h04, 8'h01);
    repeat (2) @(posedge clk_in);
    chk({15'h0000, pwm}, 0);
    final_report();
  end
endmodule
